// File: inc/srcc_defines.svh
`ifndef SRCC_DEFINES_SVH
`define SRCC_DEFINES_SVH
// =====================================================================
// Register map (7-bit register addresses)
`define SRCC_SETUP_ONE_ADDR  7'h09
`define SRCC_SETUP_TWO_ADDR  7'h0A
`define SRCC_SETUP_ONE_RST   8'h00
`define SRCC_SETUP_TWO_RST   8'h00
// Bits of receiver_setup_one
`define SRCC_UNLK_CLK_BIT    7
`define SRCC_RATIO_MSB       6
`define SRCC_RATIO_LSB       5
`define SRCC_DEEMPH_BIT      4
`define SRCC_ERR_MSB         3
`define SRCC_ERR_LSB         2
`define SRCC_LOCK_MSB        1
`define SRCC_LOCK_LSB        0
// Bits of receiver_setup_two
`define SRCC_SILENCE_BIT     7
`define SRCC_PORT_REF_BIT    6
`define SRCC_PORT_SEL_MSB    5
`define SRCC_PORT_SEL_LSB    4
`define SRCC_BLK_NONPCM_BIT  1
`define SRCC_BLK_INVAL_BIT   0
`define SRCC_SETUP_TWO_MASK  8'hF3
// Soft mute: one 6 dB step per sample, silent after this many steps
`define SRCC_ATT_LAST        5'h18
`endif

// File: inc/srcc_pkg.sv
package srcc_pkg;
   typedef enum logic [1:0] {
      SRCC_ERR_NONE = 2'b00,
      SRCC_ERR_HOLD = 2'b01,
      SRCC_ERR_ZERO = 2'b10,
      SRCC_ERR_RSVD = 2'b11
   } srcc_err_act_t;
   typedef enum logic [1:0] {
      SRCC_LOCK_NONE = 2'b00,
      SRCC_LOCK_HOLD = 2'b01,
      SRCC_LOCK_ZERO = 2'b10,
      SRCC_LOCK_SOFT = 2'b11
   } srcc_lock_act_t;
endpackage : srcc_pkg

// File: verilog/srcc_rx_ctrl.sv
// What this block does
// - Unlocked: recovered clock if bit 0, else internal
// - Ratio codes pick 128, 256, 512 times fs
// - Auto de-emphasis follows channel status when enabled
// - Error action: none, hold last, or zero
// - Unlock action: none, hold, zeros, soft mute
// - Hard silence bit zeroes receiver audio output
// - Reference: preamble clock, or serial port clock
// - Port select: playback, aux in, record, aux out
// - Non-audio blocking bit stops data to converter
// - Compressed payload never reaches the converter
// - Validity blocking bit stops data to converter
`timescale 1ns/100ps
`include "srcc_defines.svh"

// =====================================================================
// Sample FIFO
module srcc_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_sys,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
   } srcc_fifo_state_t;
   srcc_fifo_state_t q;
   srcc_fifo_state_t d;
   logic push;
   logic pop;

   // Pointers wrap by overflow, so only power-of-two depths keep the order
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_params
      $error("srcc_fifo: DEPTH must be a power of two of at least 2");
   end

   assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (q.cnt != '0);
   assign out_data  = q.mem[q.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wr] = in_data;
         d.wr        = q.wr + 1'b1;
      end
      if (pop) begin
         d.rd = q.rd + 1'b1;
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : srcc_fifo

// =====================================================================
// Receiver configuration and sample handling
module srcc_rx_ctrl #(
   parameter int SAMPLE_W   = 24,
   parameter int FIFO_DEPTH = 4
) (
   input  wire logic                clk_sys,
   input  wire logic                reset,
   // Register port from the control interface
   input  wire logic [6:0]          reg_addr,
   input  wire logic                reg_wr,
   input  wire logic [7:0]          reg_wdata,
   output      logic [7:0]          reg_rdata,
   // Receiver status
   input  wire logic                pll_locked,
   // Decoded samples from the biphase receiver
   input  wire logic                smp_valid,
   output      logic                smp_ready,
   input  wire logic [SAMPLE_W-1:0] smp_data,
   input  wire logic                smp_err,
   input  wire logic                smp_invalid,
   input  wire logic                smp_nonpcm,
   input  wire logic                smp_emph,
   // Clock and reference steering
   output      logic                rx_clk_use_iclk,
   output      logic [1:0]          rx_clk_ratio,
   output      logic                pll_ref_port,
   output      logic [1:0]          pll_ref_port_sel,
   // Receiver audio out, converter feed shares the same words
   output      logic                dir_valid,
   input  wire logic                dir_ready,
   output      logic [SAMPLE_W-1:0] dir_data,
   output      logic                src_valid
);
   typedef struct packed {
      logic [7:0]          setup_one;
      logic [7:0]          setup_two;
      logic [7:0]          rdata;
      logic [1:0]          lock_sync;
      logic [SAMPLE_W-1:0] last;
      logic [SAMPLE_W-1:0] deemph_y;
      logic [4:0]          att;
      logic                word_vld;
      logic                word_src;
      logic [SAMPLE_W-1:0] word;
      logic                use_iclk;
   } srcc_state_t;

   srcc_state_t q;
   srcc_state_t d;
   logic        locked;
   logic        accept;
   logic        fifo_ready;
   logic        fifo_src;

   srcc_pkg::srcc_err_act_t  err_act;
   srcc_pkg::srcc_lock_act_t lock_act;

   // Refused at elaboration rather than left to misbehave at run time
   if (SAMPLE_W < 8 || FIFO_DEPTH < 2) begin : g_bad_params
      $error("srcc_rx_ctrl: unsupported SAMPLE_W or FIFO_DEPTH");
   end

   // First-order shelf; unity at DC, one third (roughly 9.5 dB down) at fs/2
   function automatic logic [SAMPLE_W-1:0] deemph(input logic [SAMPLE_W-1:0] x,
                                                   input logic [SAMPLE_W-1:0] y);
      logic signed [SAMPLE_W:0] xs;
      logic signed [SAMPLE_W:0] ys;
      logic signed [SAMPLE_W:0] s;
      xs = $signed({x[SAMPLE_W-1], x});
      ys = $signed({y[SAMPLE_W-1], y});
      s  = xs - (xs >>> 1) + (ys >>> 1);
      return s[SAMPLE_W-1:0];
   endfunction : deemph

   assign locked    = q.lock_sync[1];
   assign err_act   = srcc_pkg::srcc_err_act_t'(q.setup_one[`SRCC_ERR_MSB:`SRCC_ERR_LSB]);
   assign lock_act  = srcc_pkg::srcc_lock_act_t'(q.setup_one[`SRCC_LOCK_MSB:`SRCC_LOCK_LSB]);
   // The output stage may refill when it is empty or when the FIFO takes its word
   assign smp_ready = !q.word_vld || fifo_ready;
   assign accept    = smp_valid && smp_ready;

   assign reg_rdata        = q.rdata;
   assign rx_clk_use_iclk  = q.use_iclk;
   assign rx_clk_ratio     = q.setup_one[`SRCC_RATIO_MSB:`SRCC_RATIO_LSB];
   assign pll_ref_port     = q.setup_two[`SRCC_PORT_REF_BIT];
   assign pll_ref_port_sel = q.setup_two[`SRCC_PORT_SEL_MSB:`SRCC_PORT_SEL_LSB];
   assign src_valid        = dir_valid && fifo_src;

   always_comb begin
      logic [SAMPLE_W-1:0] smp;
      logic                good;
      smp  = smp_data;
      good = 1'b1;
      d    = q;
      d.lock_sync = {q.lock_sync[0], pll_locked};
      d.use_iclk  = !locked && q.setup_one[`SRCC_UNLK_CLK_BIT];
      // Register port
      if (reg_wr && reg_addr == `SRCC_SETUP_ONE_ADDR) begin
         d.setup_one = reg_wdata;
      end
      // Reserved bits are kept at zero regardless of what is written
      if (reg_wr && reg_addr == `SRCC_SETUP_TWO_ADDR) begin
         d.setup_two = reg_wdata & `SRCC_SETUP_TWO_MASK;
      end
      if (reg_addr == `SRCC_SETUP_ONE_ADDR) begin
         d.rdata = q.setup_one;
      end else if (reg_addr == `SRCC_SETUP_TWO_ADDR) begin
         d.rdata = q.setup_two;
      end else begin
         d.rdata = 8'h00;
      end
      // Output stage drains into the FIFO
      if (q.word_vld && fifo_ready) begin
         d.word_vld = 1'b0;
      end
      if (locked) begin
         d.att = '0;
      end
      if (accept) begin
         if (!locked) begin
            good = 1'b0;
            unique case (lock_act)
               srcc_pkg::SRCC_LOCK_NONE: smp = smp_data;
               srcc_pkg::SRCC_LOCK_HOLD: smp = q.last;
               srcc_pkg::SRCC_LOCK_ZERO: smp = '0;
               srcc_pkg::SRCC_LOCK_SOFT: begin
                  smp = (q.att >= `SRCC_ATT_LAST) ? '0 : SAMPLE_W'($signed(q.last) >>> q.att);
                  if (q.att < `SRCC_ATT_LAST) begin
                     d.att = q.att + 5'h01;
                  end
               end
            endcase
         end else if (smp_err) begin
            good = 1'b0;
            unique case (err_act)
               srcc_pkg::SRCC_ERR_HOLD: smp = q.last;
               srcc_pkg::SRCC_ERR_ZERO: smp = '0;
               // Reserved code behaves as no action
               srcc_pkg::SRCC_ERR_NONE,
               srcc_pkg::SRCC_ERR_RSVD: smp = smp_data;
            endcase
         end
         if (good) begin
            d.last = smp_data;
         end
         // Filter state only advances on emphasised material
         if (q.setup_one[`SRCC_DEEMPH_BIT] && smp_emph) begin
            smp        = deemph(smp, q.deemph_y);
            d.deemph_y = smp;
         end
         if (q.setup_two[`SRCC_SILENCE_BIT]) begin
            smp = '0;
         end
         d.word     = smp;
         d.word_vld = 1'b1;
         d.word_src = !q.setup_two[`SRCC_BLK_NONPCM_BIT]
                      && !smp_nonpcm
                      && !q.setup_two[`SRCC_BLK_INVAL_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         q           <= '0;
         q.setup_one <= `SRCC_SETUP_ONE_RST;
         q.setup_two <= `SRCC_SETUP_TWO_RST;
      end else begin
         q <= d;
      end
   end

   srcc_fifo #(
      .WIDTH (SAMPLE_W + 1),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .in_valid  (q.word_vld),
      .in_ready  (fifo_ready),
      .in_data   ({q.word_src, q.word}),
      .out_valid (dir_valid),
      .out_ready (dir_ready),
      .out_data  ({fifo_src, dir_data})
   );

   // =====================================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_unlocked_clock_pick: assert property (##1 rx_clk_use_iclk == $past(!locked && q.setup_one[7]))
      else $error("receiver clock source does not follow lock and select bit");
   a_ratio_follows_reg: assert property (reg_wr && reg_addr == 7'h09 |=> rx_clk_ratio == $past(reg_wdata[6:5]))
      else $error("clock ratio output does not follow register write");
   a_deemph_off_pass: assert property (accept && locked && !smp_err && q.setup_one[4:4] == 1'b0
         && !q.setup_two[7] |=> q.word == $past(smp_data))
      else $error("sample altered with de-emphasis off");
   a_err_zero_fill: assert property (accept && locked && smp_err && q.setup_one[3:2] == 2'b10
         && !q.setup_one[4] && !q.setup_two[7] |=> q.word == '0)
      else $error("errored sample not zeroed");
   a_err_hold_last: assert property (accept && locked && smp_err && q.setup_one[3:2] == 2'b01
         && !q.setup_one[4] && !q.setup_two[7] |=> q.word == $past(q.last))
      else $error("errored sample not replaced by last good one");
   a_unlock_zeros: assert property (accept && !locked && q.setup_one[1:0] == 2'b10
         && !q.setup_one[4] |=> q.word == '0)
      else $error("unlocked sample not zeroed");
   a_unlock_hold_last: assert property (accept && !locked && q.setup_one[1:0] == 2'b01 && !q.setup_one[4]
         && !q.setup_two[7] |=> q.word == $past(q.last))
      else $error("unlocked sample not replaced by last good one");
   a_hard_silence: assert property (accept && q.setup_two[7] |=> q.word == '0 && q.word_vld)
      else $error("hard silence did not zero the sample");
   a_ref_port_write: assert property (reg_wr && reg_addr == `SRCC_SETUP_TWO_ADDR
         |=> pll_ref_port == $past(reg_wdata[6]) && pll_ref_port_sel == $past(reg_wdata[5:4]))
      else $error("reference selection does not follow register write");
   a_block_nonpcm: assert property (accept && (smp_nonpcm || q.setup_two[1]) |=> !q.word_src)
      else $error("non-audio word marked for converter");
   a_block_invalid: assert property (accept && q.setup_two[0] |=> !q.word_src)
      else $error("validity blocking ignored");
   a_nonpcm_bit_block: assert property (accept && q.setup_two[`SRCC_BLK_NONPCM_BIT] |=> !q.word_src)
      else $error("non-audio blocking bit ignored");
   a_clear_bits_pass: assert property (accept && !smp_nonpcm && q.setup_two[1:0] == 2'b00 |=> q.word_src)
      else $error("audio word withheld from converter with blocking off");

   c_soft_mute_done: cover property (!locked && q.att == 5'h18);
   c_fifo_full:      cover property (!fifo_ready ##1 dir_ready);
   c_src_word:       cover property (src_valid && dir_ready);
   c_err_hold:       cover property (accept && locked && smp_err && err_act == srcc_pkg::SRCC_ERR_HOLD);
   c_unlock_hold:    cover property (accept && !locked && lock_act == srcc_pkg::SRCC_LOCK_HOLD);
endmodule : srcc_rx_ctrl

// File: verif/srcc_spdif_src.sv
`timescale 1ns/100ps
// =====================================================================
// Far-end source: decoded words queued by the bench, flags {emph,nonpcm,invalid,err}
module srcc_spdif_src (
   input  wire logic        clk_sys,
   input  wire logic        smp_ready,
   output      logic        smp_valid,
   output      logic [23:0] smp_data,
   output      logic [3:0]  smp_flags
);
   logic [27:0] q[$];
   logic        took = 1'b0;
   initial begin
      smp_valid = 1'b0;
      smp_data  = 24'h000000;
      smp_flags = 4'h0;
   end
   always @(posedge clk_sys) took <= smp_valid & smp_ready;
   // Word held until accepted; idle data toggles so a stale word never looks valid
   always @(negedge clk_sys) begin
      if (took) void'(q.pop_front());
      if (q.size() != 0) begin
         smp_valid = 1'b1;
         {smp_flags, smp_data} = q[0];
      end else begin
         smp_valid = 1'b0;
         smp_data  = ~smp_data;
      end
   end
   function automatic void push(input logic [27:0] w);
      q.push_back(w);
   endfunction : push
endmodule : srcc_spdif_src

// File: verif/tb_srcc_rx_ctrl.sv
`timescale 1ns/100ps
module tb_srcc_rx_ctrl;
   logic        clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, pll_locked = 1'b0, dir_ready = 1'b0;
   logic [6:0]  reg_addr = 7'h00;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata;
   logic        smp_valid, smp_ready, rx_clk_use_iclk, pll_ref_port, dir_valid, src_valid;
   logic [23:0] smp_data, dir_data, a, b;
   logic [3:0]  flg;
   logic [1:0]  rx_clk_ratio, pll_ref_port_sel;
   logic [7:0]  v;
   int          mismatches = 0, checked = 0, seed = 77141;
   srcc_rx_ctrl DUT (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pll_locked(pll_locked), .smp_valid(smp_valid),
      .smp_ready(smp_ready), .smp_data(smp_data), .smp_err(flg[0]), .smp_invalid(flg[1]),
      .smp_nonpcm(flg[2]), .smp_emph(flg[3]), .rx_clk_use_iclk(rx_clk_use_iclk),
      .rx_clk_ratio(rx_clk_ratio), .pll_ref_port(pll_ref_port), .pll_ref_port_sel(pll_ref_port_sel),
      .dir_valid(dir_valid), .dir_ready(dir_ready), .dir_data(dir_data), .src_valid(src_valid));
   srcc_spdif_src u_src (.clk_sys(clk_sys), .smp_ready(smp_ready), .smp_valid(smp_valid),
      .smp_data(smp_data), .smp_flags(flg));
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   // =====================================================================
   // Checking and bus tasks
   task automatic wrap_up();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up
   task automatic chk_word(input string n, input logic [23:0] e, input logic [23:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk_word
   task automatic chk_bit(input string n, input logic e, input logic g);
      chk_word(n, {23'h0, e}, {23'h0, g});
   endtask : chk_bit
   task automatic wr(input logic [6:0] ad, input logic [7:0] d);
      reg_addr  = ad;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      @(negedge clk_sys);
   endtask : wr
   task automatic rd(input logic [6:0] ad, input logic [7:0] e);
      reg_addr = ad;
      repeat (2) @(negedge clk_sys);
      chk_word("reg_rdata", {16'h0000, e}, {16'h0000, reg_rdata});
   endtask : rd
   task automatic lock(input logic l);
      pll_locked = l;
      repeat (4) @(negedge clk_sys);
   endtask : lock
   task automatic get(input logic [23:0] e, input logic es);
      int i;
      for (i = 0; i < 60 && dir_valid !== 1'b1; i++) @(negedge clk_sys);
      if (dir_valid !== 1'b1) begin
         mismatches++;
         wrap_up();
      end
      chk_word("dir_data", e, dir_data);
      chk_bit("src_valid", es, src_valid);
      dir_ready = 1'b1;
      @(negedge clk_sys);
      dir_ready = 1'b0;
   endtask : get
   task automatic xfer(input logic [27:0] w, input logic [23:0] e, input logic es);
      u_src.push(w);
      get(e, es);
   endtask : xfer
   // Soft mute shifts one more step per sample and is silent from the 25th on
   function automatic logic [23:0] soft_exp(input logic [23:0] x, input int j);
      return (j >= 24) ? 24'h000000 : 24'($signed(x) >>> j);
   endfunction : soft_exp
   // =====================================================================
   // Main sequence
   initial begin
      repeat (16) @(negedge clk_sys);
      reset = 1'b0;
      rd(7'h09, 8'h00);
      rd(7'h0A, 8'h00);
      lock(1'b1);
      a = $random(seed) & 24'h3FFFFE;
      wr(7'h09, 8'h10);
      xfer({4'h8, a}, a >> 1, 1'b1);
      xfer({4'h0, a}, a, 1'b1);
      wr(7'h09, 8'h00);
      xfer({4'h8, a}, a, 1'b1);
      for (int k = 0; k < 4; k++) begin
         v = $random(seed);
         wr(7'h09, {v[7], 2'(k % 3), v[4], 1'b0, v[2:0]});
         chk_word("rx_clk_ratio", 24'(k % 3), {22'h0, rx_clk_ratio});
         rd(7'h09, {v[7], 2'(k % 3), v[4], 1'b0, v[2:0]});
         wr(7'h0A, {v[7:6], 2'(k), 2'b00, v[1:0]});
         chk_bit("pll_ref_port", v[6], pll_ref_port);
         chk_word("pll_ref_port_sel", 24'(k), {22'h0, pll_ref_port_sel});
      end
      wr(7'h0A, 8'hFF);
      rd(7'h0A, 8'hF3);
      wr(7'h09, 8'h80);
      wr(7'h0B, 8'hFF);
      rd(7'h09, 8'h80);
      rd(7'h15, 8'h00);
      lock(1'b0);
      chk_bit("rx_clk_use_iclk", 1'b1, rx_clk_use_iclk);
      wr(7'h09, 8'h00);
      chk_bit("rx_clk_use_iclk", 1'b0, rx_clk_use_iclk);
      wr(7'h09, 8'h80);
      lock(1'b1);
      chk_bit("rx_clk_use_iclk", 1'b0, rx_clk_use_iclk);
      wr(7'h09, 8'h00);
      wr(7'h0A, 8'h00);
      a = $random(seed);
      xfer({4'h2, a}, a, 1'b1);
      xfer({4'h4, a}, a, 1'b0);
      wr(7'h0A, 8'h02);
      xfer({4'h0, a}, a, 1'b0);
      wr(7'h0A, 8'h01);
      xfer({4'h0, a}, a, 1'b0);
      wr(7'h0A, 8'h80);
      xfer({4'h0, a}, 24'h000000, 1'b1);
      wr(7'h0A, 8'h00);
      for (int c = 0; c < 3; c++) begin
         a = $random(seed);
         b = $random(seed);
         wr(7'h09, 8'(c << 2));
         xfer({4'h0, a}, a, 1'b1);
         xfer({4'h1, b}, (c == 0) ? b : (c == 1) ? a : 24'h000000, 1'b1);
         wr(7'h09, 8'(c));
         xfer({4'h0, a}, a, 1'b1);
         lock(1'b0);
         xfer({4'h0, b}, (c == 0) ? b : (c == 1) ? a : 24'h000000, 1'b1);
         lock(1'b1);
      end
      a = $random(seed) & 24'h7FFFFF;
      wr(7'h09, 8'h03);
      xfer({4'h0, a}, a, 1'b1);
      lock(1'b0);
      for (int j = 0; j < 26; j++) xfer({4'h0, b}, soft_exp(a, j), 1'b1);
      lock(1'b1);
      wr(7'h09, 8'h00);
      // Stalled consumer: five words fill stage and FIFO, the sixth is refused
      for (int k = 1; k < 7; k++) u_src.push({4'h0, 24'(k)});
      repeat (20) @(negedge clk_sys);
      chk_bit("smp_ready", 1'b0, smp_ready);
      for (int k = 1; k < 7; k++) get(24'(k), 1'b1);
      wrap_up();
   end
endmodule : tb_srcc_rx_ctrl
